// ### sim/host_wake_handshake_serial_test.sv
// self-checking bench for both handshake ends
`timescale 1ns/10ps
`default_nettype none
module host_wake_handshake_serial_test;
   import hws_pkg::*;
   localparam int SETTLE = 20;
   localparam int PULSE = 20;
   logic ref_clk = 0;
   logic rst_n = 0;
   logic rx_activity = 0, rf_field = 0, target_activated = 0, cmd_frame_done = 0, ack_sent = 0;
   logic cmd_target_init = 0, cmd_sam_config = 0, cpu_power_down_set = 0, module_event = 0;
   logic response_done = 0, wake_request = 0, response_seen = 0;
   hws_mode_e sam_mode = HWS_MODE_NORMAL;
   logic asleep, rx_ready, send_response, ack_due, ack_overdue, host_notify;
   logic may_send, device_notify, pad_byte_valid;
   logic [7:0] pad_byte;
   int n_fail = 0;
   int n_checks = 0;
   hws_link_if link();
   always #5 ref_clk = ~ref_clk;
   hws_device #(.WAKE_LIMIT(50), .SETTLE(SETTLE), .ACK_LIMIT(60)) u_hws_device (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .rx_activity(rx_activity),
      .rf_field(rf_field), .target_activated(target_activated), .cmd_frame_done(cmd_frame_done),
      .ack_sent(ack_sent), .cmd_target_init(cmd_target_init), .cmd_sam_config(cmd_sam_config),
      .sam_mode(sam_mode), .cpu_power_down_set(cpu_power_down_set), .module_event(module_event),
      .response_done(response_done), .asleep(asleep), .rx_ready(rx_ready),
      .send_response(send_response), .ack_due(ack_due), .ack_overdue(ack_overdue),
      .host_notify(host_notify));
   hws_host #(.WAKE_PULSE(PULSE), .WIRED(1'b1)) u_hws_host (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .wake_request(wake_request),
      .response_seen(response_seen), .may_send(may_send), .device_notify(device_notify),
      .pad_byte_valid(pad_byte_valid), .pad_byte(pad_byte));
   hws_link_properties #(.WAKE_LIMIT(50), .WAKE_PULSE(PULSE)) u_hws_link_properties (
      .ref_clk(ref_clk), .rst_n(rst_n),
      .device_to_host_request_n(link.device_to_host_request_n),
      .host_request_n(link.host_request_n), .host_request_wired(link.host_request_wired));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      @(negedge ref_clk);
      s = 0;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100us;
      n_fail++;
      report_and_stop;
   end
   initial begin
      int k;
      wait_cyc(16);
      rst_n = 1;
      check("req_n", link.device_to_host_request_n, 1);
      check("host_req_n", link.host_request_n, 1);
      check("rx_ready", rx_ready, 1);
      check("pad", {pad_byte_valid, pad_byte}, {1'b1, FRAME_PAD_BYTE});
      pulse(target_activated);
      wait_cyc(1);
      check("req_n low", link.device_to_host_request_n, 0);
      check("notify", host_notify, 1);
      k = 0;
      while (send_response !== 1'b1 && k < 20) begin
         @(negedge ref_clk);
         k++;
      end
      check("resp pulse", send_response, 1);
      check("host acked", link.host_request_n, 0);
      check("dev notify", device_notify, 1);
      check("req_n released", link.device_to_host_request_n, 1);
      pulse(response_done);
      pulse(response_seen);
      wait_cyc(8);
      pulse(cmd_target_init);
      pulse(ack_sent);
      wait_cyc(1);
      check("asleep init", asleep, 1);
      rf_field = 1;
      wait_cyc(3);
      check("settling", rx_ready, 0);
      wait_cyc(SETTLE + 2);
      check("woken field", rx_ready, 1);
      rf_field = 0;
      pulse(cpu_power_down_set);
      wait_cyc(1);
      check("asleep cpu", asleep, 1);
      pulse(wake_request);
      wait_cyc(3);
      check("host hold", may_send, 0);
      wait_cyc(2 * PULSE + SETTLE);
      check("may send", may_send, 1);
      check("woken pin", rx_ready, 1);
      pulse(cpu_power_down_set);
      pulse(rx_activity);
      wait_cyc(SETTLE + 4);
      check("woken data", rx_ready, 1);
      pulse(cmd_frame_done);
      check("ack due", ack_due, 1);
      wait_cyc(57);
      check("ack in time", ack_overdue, 0);
      wait_cyc(5);
      check("ack late", ack_overdue, 1);
      pulse(ack_sent);
      wait_cyc(1);
      check("ack clear", ack_overdue, 0);
      sam_mode = HWS_MODE_LOW_BATTERY;
      pulse(cmd_sam_config);
      rf_field = 1;
      pulse(ack_sent);
      rf_field = 0;
      pulse(target_activated);
      pulse(module_event);
      wait_cyc(2);
      check("lowbat quiet", link.device_to_host_request_n, 1);
      check("lowbat notify", host_notify, 0);
      pulse(cmd_sam_config);
      pulse(ack_sent);
      wait_cyc(1);
      check("lowbat sleep", asleep, 1);
      rst_n = 0;
      wait_cyc(16);
      rst_n = 1;
      wait_cyc(2);
      check("req_n again", link.device_to_host_request_n, 1);
      report_and_stop;
   end
endmodule
`default_nettype wire

// ### sim/hws_link_properties.sv
// interface-level properties of the wake handshake
`timescale 1ns/10ps
`default_nettype none
module hws_link_properties #(
   parameter int WAKE_LIMIT = 50,
   parameter int WAKE_PULSE = 20
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic device_to_host_request_n,
   input wire logic host_request_n,
   input wire logic host_request_wired
);
   int low_cnt;
   int hlow_cnt;
   logic ack_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // low-time counters and ack marker
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= 0;
         hlow_cnt <= 0;
         ack_r <= 1'b0;
      end else begin
         low_cnt <= device_to_host_request_n ? 0 : low_cnt + 1;
         hlow_cnt <= host_request_n ? 0 : hlow_cnt + 1;
         if (host_request_n) ack_r <= !device_to_host_request_n;
      end
   end
   a_reset_req_high: assert property ($rose(rst_n) |-> device_to_host_request_n)
      else $error("request line low after reset");
   a_reset_host_idle: assert property ($rose(rst_n) |-> host_request_n)
      else $error("host line active after reset");
   a_fall_sync_delay: assert property ($fell(host_request_n) && !device_to_host_request_n
      |=> !device_to_host_request_n)
      else $error("request released before synchronised edge");
   a_fall_release: assert property ($fell(host_request_n) && !device_to_host_request_n
      |-> ##[2:4] device_to_host_request_n)
      else $error("request not released after host edge");
   a_host_ack_low: assert property ($fell(device_to_host_request_n) && host_request_wired
      |-> ##[2:5] !host_request_n)
      else $error("host did not acknowledge");
   a_host_release: assert property ($rose(device_to_host_request_n) && !host_request_n
      |-> ##[1:5] host_request_n)
      else $error("host line not released");
   a_request_bounded: assert property (low_cnt <= WAKE_LIMIT + 2)
      else $error("request held too long");
   a_wake_pulse_len: assert property ($rose(host_request_n) && !ack_r
      |-> hlow_cnt >= WAKE_PULSE)
      else $error("host wake pulse too short");
endmodule
`default_nettype wire

// ### src/hws_device.sv
// device end of the wake and target-activation handshake
// Notes on behaviour
// - host frames use single 0x00 pre/postamble
// - incoming serial data alone wakes device
// - host request forces wake before receive
// - drive request line except low-battery mode
// - after target-init ack, sleep without field
// - low-battery/card mode: sleep after ack, no field
// - cpu power-mode variable sleep value sleeps
// - low-battery: ignore lines, no module reports
// - host uses long preamble in low-battery; hws_host keeps the single 0x00 pad_byte in every mode
// - same behaviour with or without host request
// - host wake pulse at least oscillator start
// - serial wake uses long preamble form; hws_host keeps the single 0x00 pad_byte
// - no wake indication; wait oscillator start
// - wake on RF field or new command
// - ack target-init first, then sleep
// - activated target pulls request line low
// - host acknowledges with its request low
// - host falling edge: send response, release
// - host may sleep after exchange
// - unwired host line: 12 ms then send
// - ack each command within 15 ms
// - full duplex serial, up to 1.288 Mbaud
`timescale 1ns/10ps
`default_nettype none
module hws_device
   import hws_pkg::*;
#(
   parameter int WAKE_LIMIT = WAKE_PULSE_LIMIT_CYC,
   parameter int SETTLE = OSC_START_CYC,
   parameter int ACK_LIMIT = ACK_LIMIT_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   hws_link_if.device link,
   input wire logic rx_activity,
   input wire logic rf_field,
   input wire logic target_activated,
   input wire logic cmd_frame_done,
   input wire logic ack_sent,
   input wire logic cmd_target_init,
   input wire logic cmd_sam_config,
   input wire hws_mode_e sam_mode,
   input wire logic cpu_power_down_set,
   input wire logic module_event,
   input wire logic response_done,
   output logic asleep,
   output logic rx_ready,
   output logic send_response,
   output logic ack_due,
   output logic ack_overdue,
   output logic host_notify
);
   hws_dev_state_e state_r;
   hws_mode_e mode_r;
   logic req_fall;
   logic sleep_pending_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] ack_cnt_r;
   logic irq_r;
   logic low_bat;
   logic wake_req;
   hws_sync_edge u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(link.host_request_n),
      .level(),
      .fall(req_fall)
   );
   assign low_bat = (mode_r == HWS_MODE_LOW_BATTERY);
   // host line ignored in low-battery mode
   assign wake_req = rx_activity | rf_field | (!low_bat && req_fall);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= HWS_MODE_NORMAL;
      end else if (cmd_sam_config) begin
         mode_r <= sam_mode;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_pending_r <= 1'b0;
      end else if (cmd_target_init || (cmd_sam_config && sam_mode != HWS_MODE_NORMAL)) begin
         sleep_pending_r <= 1'b1;
      end else if (ack_sent) begin
         sleep_pending_r <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_cnt_r <= '0;
         ack_due <= 1'b0;
         ack_overdue <= 1'b0;
      end else if (cmd_frame_done) begin
         // a new command restarts the timer even when an ack leaves in the same cycle
         ack_due <= 1'b1;
         ack_overdue <= 1'b0;
         ack_cnt_r <= '0;
      end else if (ack_sent) begin
         ack_due <= 1'b0;
         ack_overdue <= 1'b0;
         ack_cnt_r <= '0;
      end else if (ack_due && ack_cnt_r != CNT_W'(ACK_LIMIT - 1)) begin
         ack_cnt_r <= ack_cnt_r + 1'b1;
      end else if (ack_due) begin
         ack_overdue <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= HWS_DEV_AWAKE;
         cnt_r <= '0;
         irq_r <= LINE_IDLE;
         send_response <= 1'b0;
      end else begin
         send_response <= 1'b0;
         unique case (state_r)
            HWS_DEV_AWAKE: begin
               if (ack_sent && sleep_pending_r && !rf_field) begin
                  state_r <= HWS_DEV_SLEEP;
               end else if (cpu_power_down_set) begin
                  state_r <= HWS_DEV_SLEEP;
               end else if (!low_bat && (target_activated || module_event)) begin
                  state_r <= HWS_DEV_WAIT_HOST;
                  irq_r <= LINE_ACTIVE;
                  cnt_r <= '0;
               end
            end
            HWS_DEV_SLEEP: begin
               if (wake_req) begin
                  state_r <= HWS_DEV_SETTLE;
                  cnt_r <= '0;
               end
            end
            HWS_DEV_SETTLE: begin
               if (cnt_r == CNT_W'(SETTLE - 1)) begin
                  state_r <= HWS_DEV_AWAKE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            HWS_DEV_WAIT_HOST: begin
               if ((link.host_request_wired && req_fall) ||
                   cnt_r == CNT_W'(WAKE_LIMIT - 1)) begin
                  state_r <= HWS_DEV_SEND;
                  send_response <= 1'b1;
                  irq_r <= LINE_IDLE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            HWS_DEV_SEND: begin
               if (response_done) begin
                  state_r <= HWS_DEV_AWAKE;
               end
            end
         endcase
      end
   end
   assign link.device_to_host_request_n = irq_r;
   assign asleep = (state_r == HWS_DEV_SLEEP);
   assign rx_ready = (state_r != HWS_DEV_SLEEP) && (state_r != HWS_DEV_SETTLE);
   assign host_notify = (state_r == HWS_DEV_WAIT_HOST);
endmodule
`default_nettype wire

// ### src/hws_host.sv
// host end of the wake and target-activation handshake
`timescale 1ns/10ps
`default_nettype none
module hws_host
   import hws_pkg::*;
#(
   parameter int WAKE_PULSE = OSC_START_CYC,
   parameter logic WIRED = 1'b1
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   hws_link_if.host link,
   input wire logic wake_request,
   input wire logic response_seen,
   output logic may_send,
   output logic device_notify,
   output logic pad_byte_valid,
   output logic [7:0] pad_byte
);
   hws_host_state_e state_r;
   logic [CNT_W-1:0] cnt_r;
   logic dev_level;
   logic dev_fall;
   logic req_r;
   hws_sync_edge u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .async_in(link.device_to_host_request_n),
      .level(dev_level),
      .fall(dev_fall)
   );
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= HWS_HOST_IDLE;
         cnt_r <= '0;
         req_r <= LINE_IDLE;
      end else begin
         unique case (state_r)
            HWS_HOST_IDLE: begin
               if (dev_fall && WIRED) begin
                  state_r <= HWS_HOST_ACK_LOW;
                  req_r <= LINE_ACTIVE;
               end else if (wake_request) begin
                  state_r <= HWS_HOST_WAKE_PULSE;
                  req_r <= LINE_ACTIVE;
                  cnt_r <= '0;
               end
            end
            HWS_HOST_WAKE_PULSE: begin
               if (cnt_r == CNT_W'(WAKE_PULSE - 1)) begin
                  state_r <= HWS_HOST_WAKE_WAIT;
                  req_r <= LINE_IDLE;
                  cnt_r <= '0;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            HWS_HOST_WAKE_WAIT: begin
               if (cnt_r == CNT_W'(WAKE_PULSE - 1)) begin
                  state_r <= HWS_HOST_IDLE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            HWS_HOST_ACK_LOW: begin
               if (dev_level == LINE_IDLE || response_seen) begin
                  state_r <= HWS_HOST_IDLE;
                  req_r <= LINE_IDLE;
               end
            end
         endcase
      end
   end
   assign link.host_request_n = req_r;
   assign link.host_request_wired = WIRED;
   assign may_send = (state_r == HWS_HOST_IDLE);
   assign device_notify = (state_r == HWS_HOST_ACK_LOW);
   assign pad_byte_valid = 1'b1;
   assign pad_byte = FRAME_PAD_BYTE;
endmodule
`default_nettype wire

// ### src/hws_link_if.sv
// handshake lines between device and host
`timescale 1ns/10ps
`default_nettype none
interface hws_link_if;
   logic device_to_host_request_n;
   logic host_request_n;
   logic host_request_wired;
   modport device (
      output device_to_host_request_n,
      input host_request_n,
      input host_request_wired
   );
   modport host (
      input device_to_host_request_n,
      output host_request_n,
      output host_request_wired
   );
endinterface
`default_nettype wire

// ### src/hws_pkg.sv
// constants and types shared by both ends of the wake handshake
package hws_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int US_PER_S = 1_000_000;
   localparam int WAKE_PULSE_LIMIT_MS = 12;
   localparam int ACK_LIMIT_MS = 15;
   localparam int OSC_START_US = 2000;
   localparam int WAKE_PULSE_LIMIT_CYC = WAKE_PULSE_LIMIT_MS * (CLK_HZ / MS_PER_S);
   localparam int ACK_LIMIT_CYC = ACK_LIMIT_MS * (CLK_HZ / MS_PER_S);
   localparam int OSC_START_CYC = OSC_START_US * (CLK_HZ / US_PER_S);
   localparam int CNT_W = 24;
   localparam logic [7:0] FRAME_PAD_BYTE = 8'h00;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_ACTIVE = 1'b0;
   typedef enum logic [1:0] {
      HWS_MODE_NORMAL,
      HWS_MODE_VIRTUAL_CARD,
      HWS_MODE_LOW_BATTERY
   } hws_mode_e;
   typedef enum {
      HWS_DEV_AWAKE,
      HWS_DEV_SLEEP,
      HWS_DEV_SETTLE,
      HWS_DEV_WAIT_HOST,
      HWS_DEV_SEND
   } hws_dev_state_e;
   typedef enum {
      HWS_HOST_IDLE,
      HWS_HOST_WAKE_PULSE,
      HWS_HOST_WAKE_WAIT,
      HWS_HOST_ACK_LOW
   } hws_host_state_e;
endpackage

// ### src/hws_sync_edge.sv
// two-flop synchroniser with falling-edge detect
`timescale 1ns/10ps
`default_nettype none
module hws_sync_edge
   import hws_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic async_in,
   output logic level,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= LINE_IDLE;
         sync_r <= LINE_IDLE;
         last_r <= LINE_IDLE;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end
   assign level = sync_r;
   assign fall = last_r & ~sync_r;
endmodule
`default_nettype wire
